// ==== energy_bucket_minmax_tracker.sv ====
// Energy bucket counters, interval count, flags and min/max tracking top
//
// What this block does
// - Interval energy is averaged power times samples per interval.
// - Interval energies accumulate; reaching one unit size bumps the counter.
// - Each energy counter is a 24-bit output register across intervals.
// - Per channel: active and reactive import and export, plus apparent.
// - Accumulators and counters zero on reset or software clear request.
// - A status flag shows that a reset has happened.
// - A readable completed-interval count restarts on reset.
// - Unit size is unsigned 48-bit fixed point in two 24-bit words.
// - Upper word integer bits, lower word fraction bits.
// - Unit size can be saved to nonvolatile storage as its default.
// - Up to six low-rate results tracked for min and max, one per slot.
// - Each slot keeps the smallest and largest value seen.
// - A zero slot pointer disables tracking for that slot.
// - Slot pointers are word addresses for every host interface.
// - Min and max results clear on reset or software clear request.
// - A status flag is set whenever a min or max value changes.
// - Slot pointers can be saved to nonvolatile storage as defaults.
`default_nettype none
`include "energy_track_regs.svh"

module energy_bucket_minmax_tracker
   import energy_track_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic interval_done,
   input wire word_t samples_per_interval,
   input wire word_t active_power_a,
   input wire word_t active_power_b,
   input wire word_t reactive_power_a,
   input wire word_t reactive_power_b,
   input wire word_t apparent_power_a,
   input wire word_t apparent_power_b,
   input wire logic clear_request,
   input wire logic unit_int_wr,
   input wire logic unit_frac_wr,
   input wire word_t unit_wdata,
   input wire logic slot_wr,
   input wire slot_idx_t slot_index,
   input wire slot_ptr_t slot_wdata,
   input wire logic [`PROD_W-1:0] nv_unit_default,
   input wire slot_table_t nv_slot_default,
   input wire logic nv_save_request,
   input wire logic reset_flag_clear,
   input wire logic minmax_flag_clear,
   input wire word_t result_data,
   output logic result_rd,
   output slot_ptr_t result_addr,
   output word_t active_import_count_a,
   output word_t active_export_count_a,
   output word_t reactive_import_count_a,
   output word_t reactive_export_count_a,
   output word_t apparent_energy_count_a,
   output word_t active_import_count_b,
   output word_t active_export_count_b,
   output word_t reactive_import_count_b,
   output word_t reactive_export_count_b,
   output word_t apparent_energy_count_b,
   output word_t energy_unit_integer_word,
   output word_t energy_unit_fraction_word,
   output slot_table_t track_slot_pointer,
   output word_t interval_count,
   output logic reset_flag,
   output logic minmax_updated,
   output value_table_t minimum_value,
   output value_table_t maximum_value,
   output logic nv_write,
   output logic [`PROD_W-1:0] nv_unit_data,
   output slot_table_t nv_slot_data
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic word_t magnitude(input word_t v);
      return v[`WORD_W-1] ? word_t'(~v + 24'h000001) : v;
   endfunction : magnitude

   // Power times samples, placed above the fraction bits of the unit size
   function automatic acc_t scaled_energy(input word_t mag,
                                          input word_t samples);
      logic [`PROD_W-1:0] prod;
      prod = `PROD_W'(mag) * `PROD_W'(samples);
      return {prod, `FRAC_BITS'h0};
   endfunction : scaled_energy

   ////////////////////////////////////////////////////////////////////////
   // Configuration, nonvolatile load and save

   word_t unit_int_reg, unit_int_next;
   word_t unit_frac_reg, unit_frac_next;
   slot_table_t slot_reg, slot_next;
   logic load_pending_reg, load_pending_next;
   logic nv_write_next;

   always_comb begin
      unit_int_next = unit_int_reg;
      unit_frac_next = unit_frac_reg;
      slot_next = slot_reg;
      load_pending_next = 1'b0;
      nv_write_next = 1'b0;
      if (load_pending_reg) begin
         // Defaults are taken after reset release, never under reset
         unit_int_next = nv_unit_default[`PROD_W-1:`FRAC_BITS];
         unit_frac_next = nv_unit_default[`FRAC_BITS-1:0];
         slot_next = nv_slot_default;
      end else begin
         if (unit_int_wr) begin
            unit_int_next = unit_wdata;
         end
         if (unit_frac_wr) begin
            unit_frac_next = unit_wdata;
         end
         if (slot_wr && slot_index < slot_idx_t'(`SLOT_COUNT)) begin
            slot_next[slot_index] = slot_wdata;
         end
         nv_write_next = nv_save_request;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         unit_int_reg <= `UNIT_INT_RESET;
         unit_frac_reg <= `UNIT_FRAC_RESET;
         slot_reg <= '0;
         load_pending_reg <= 1'b1;
         nv_write <= 1'b0;
      end else if (ce) begin
         unit_int_reg <= unit_int_next;
         unit_frac_reg <= unit_frac_next;
         slot_reg <= slot_next;
         load_pending_reg <= load_pending_next;
         nv_write <= nv_write_next;
      end
   end

   assign energy_unit_integer_word = unit_int_reg;
   assign energy_unit_fraction_word = unit_frac_reg;
   assign track_slot_pointer = slot_reg;
   // The live registers are what gets saved on a save request
   assign nv_unit_data = {unit_int_reg, unit_frac_reg};
   assign nv_slot_data = slot_reg;

   ////////////////////////////////////////////////////////////////////////
   // Energy accumulators and counters

   acc_t unit_full;
   acc_t add_val [`KIND_COUNT];
   acc_t acc_reg [`KIND_COUNT];
   acc_t acc_next [`KIND_COUNT];
   word_t cnt_reg [`KIND_COUNT];
   word_t cnt_next [`KIND_COUNT];
   logic drain [`KIND_COUNT];

   // Integer bits above, fraction bits below the binary point
   assign unit_full = {`WORD_W'h0, unit_int_reg, unit_frac_reg};

   always_comb begin
      word_t act [2];
      word_t rea [2];
      word_t app [2];
      int b;
      act[0] = active_power_a;
      act[1] = active_power_b;
      rea[0] = reactive_power_a;
      rea[1] = reactive_power_b;
      app[0] = apparent_power_a;
      app[1] = apparent_power_b;
      b = 0;
      for (int k = 0; k < `KIND_COUNT; k++) begin
         add_val[k] = '0;
      end
      for (int c = 0; c < 2; c++) begin
         b = c * `CHAN_STRIDE;
         // Sign picks import or export; the other side gets nothing
         if (act[c][`WORD_W-1]) begin
            add_val[b + `KIND_ACT_EXP] =
               scaled_energy(magnitude(act[c]), samples_per_interval);
         end else begin
            add_val[b + `KIND_ACT_IMP] =
               scaled_energy(act[c], samples_per_interval);
         end
         if (rea[c][`WORD_W-1]) begin
            add_val[b + `KIND_REA_EXP] =
               scaled_energy(magnitude(rea[c]), samples_per_interval);
         end else begin
            add_val[b + `KIND_REA_IMP] =
               scaled_energy(rea[c], samples_per_interval);
         end
         add_val[b + `KIND_APPARENT] =
            scaled_energy(app[c], samples_per_interval);
      end
   end

   // One unit drains per clock, so a large interval takes a few clocks
   // to settle; intervals are far longer than that in practice.
   always_comb begin
      for (int k = 0; k < `KIND_COUNT; k++) begin
         drain[k] = unit_full != '0 && acc_reg[k] >= unit_full;
         acc_next[k] = acc_reg[k];
         cnt_next[k] = cnt_reg[k];
         if (clear_request) begin
            acc_next[k] = '0;
            cnt_next[k] = `COUNT_RESET;
         end else begin
            if (drain[k]) begin
               acc_next[k] = acc_t'(acc_reg[k] - unit_full);
               cnt_next[k] = word_t'(cnt_reg[k] + 24'h000001);
            end
            if (interval_done) begin
               acc_next[k] = acc_t'(acc_next[k] + add_val[k]);
            end
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int k = 0; k < `KIND_COUNT; k++) begin
            acc_reg[k] <= '0;
            cnt_reg[k] <= `COUNT_RESET;
         end
      end else if (ce) begin
         for (int k = 0; k < `KIND_COUNT; k++) begin
            acc_reg[k] <= acc_next[k];
            cnt_reg[k] <= cnt_next[k];
         end
      end
   end

   assign active_import_count_a = cnt_reg[`KIND_ACT_IMP];
   assign active_export_count_a = cnt_reg[`KIND_ACT_EXP];
   assign reactive_import_count_a = cnt_reg[`KIND_REA_IMP];
   assign reactive_export_count_a = cnt_reg[`KIND_REA_EXP];
   assign apparent_energy_count_a = cnt_reg[`KIND_APPARENT];
   assign active_import_count_b = cnt_reg[`CHAN_STRIDE + `KIND_ACT_IMP];
   assign active_export_count_b = cnt_reg[`CHAN_STRIDE + `KIND_ACT_EXP];
   assign reactive_import_count_b = cnt_reg[`CHAN_STRIDE + `KIND_REA_IMP];
   assign reactive_export_count_b = cnt_reg[`CHAN_STRIDE + `KIND_REA_EXP];
   assign apparent_energy_count_b = cnt_reg[`CHAN_STRIDE + `KIND_APPARENT];

   ////////////////////////////////////////////////////////////////////////
   // Interval count and status flags

   word_t interval_next;
   logic reset_flag_next, minmax_flag_next, track_update;

   always_comb begin
      interval_next = interval_count;
      if (interval_done) begin
         interval_next = word_t'(interval_count + 24'h000001);
      end
      reset_flag_next = reset_flag && !reset_flag_clear;
      // A new update in the clearing cycle keeps the flag set
      minmax_flag_next = track_update ||
                         (minmax_updated && !minmax_flag_clear);
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         interval_count <= `COUNT_RESET;
         reset_flag <= 1'b1;
         minmax_updated <= 1'b0;
      end else if (ce) begin
         interval_count <= interval_next;
         reset_flag <= reset_flag_next;
         minmax_updated <= minmax_flag_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Min/max tracking

   minmax_tracker tracker (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .start(interval_done),
      .clear(clear_request),
      .slot_table(slot_reg),
      .result_data(result_data),
      .result_rd(result_rd),
      .result_addr(result_addr),
      .minimum_value(minimum_value),
      .maximum_value(maximum_value),
      .update(track_update)
   );

   ////////////////////////////////////////////////////////////////////////
   counter_step_a: assert property (@(posedge clk) disable iff (reset)
      ce && !clear_request && drain[0]
      |=> cnt_reg[0] == word_t'($past(cnt_reg[0]) + 24'h000001))
      else $error("counter did not advance by one");

   remainder_kept_a: assert property (@(posedge clk) disable iff (reset)
      ce && !clear_request && !interval_done && drain[0]
      |=> acc_reg[0] == acc_t'($past(acc_reg[0]) - $past(unit_full)))
      else $error("remainder lost on counter step");

   clear_zeroes_a: assert property (@(posedge clk) disable iff (reset)
      ce && clear_request
      |=> cnt_reg[0] == '0 && acc_reg[`CHAN_STRIDE] == '0
          && cnt_reg[`KIND_COUNT-1] == '0)
      else $error("energy not cleared");

   export_split_a: assert property (@(posedge clk) disable iff (reset)
      ce && interval_done && !clear_request && !drain[0] && !drain[1]
      && active_power_a[`WORD_W-1]
      |=> acc_reg[0] == $past(acc_reg[0]) && acc_reg[1] == acc_t'(
          $past(acc_reg[1]) + {`PROD_W'(magnitude($past(active_power_a)))
          * `PROD_W'($past(samples_per_interval)), `FRAC_BITS'h0}))
      else $error("export energy misrouted");

   reset_flag_hold_a: assert property (@(posedge clk) disable iff (reset)
      !reset_flag |=> !reset_flag)
      else $error("reset flag set without reset");

   interval_step_a: assert property (@(posedge clk) disable iff (reset)
      ce && interval_done
      |=> interval_count == word_t'($past(interval_count) + 24'h000001))
      else $error("interval count did not step");

   nv_save_a: assert property (@(posedge clk) disable iff (reset)
      ce && nv_save_request && !load_pending_reg
      |=> nv_write && nv_unit_data == $past(nv_unit_data))
      else $error("save request not passed on");

   minmax_flag_a: assert property (@(posedge clk) disable iff (reset)
      ce && track_update |=> minmax_updated)
      else $error("min/max update flag not set");
endmodule : energy_bucket_minmax_tracker

`default_nettype wire

// ==== energy_bucket_minmax_tracker_notes_end.sv ====
// Holds no code
`default_nettype none
`default_nettype wire

// ==== energy_track_pkg.sv ====
// Types shared by the energy counter and min/max tracker modules
`default_nettype none
`include "energy_track_regs.svh"

package energy_track_pkg;
   typedef logic [`WORD_W-1:0] word_t;
   typedef logic [`ACC_W-1:0] acc_t;
   typedef logic [`ADDR_W-1:0] slot_ptr_t;
   typedef logic [`SLOT_IDX_W-1:0] slot_idx_t;
   typedef logic [`SLOT_COUNT-1:0][`ADDR_W-1:0] slot_table_t;
   typedef logic [`SLOT_COUNT-1:0][`WORD_W-1:0] value_table_t;
   typedef enum {TRACK_IDLE, TRACK_ISSUE, TRACK_WAIT, TRACK_CAPTURE}
      track_state_e;
endpackage : energy_track_pkg

`default_nettype wire

// ==== energy_track_regs.svh ====
// Constants shared by the energy counters and the min/max tracker
`ifndef ENERGY_TRACK_REGS_SVH
`define ENERGY_TRACK_REGS_SVH

// Word and table sizes
`define WORD_W 24
`define ADDR_W 16
`define SLOT_COUNT 6
`define SLOT_IDX_W 3

// Energy unit size is 24 integer bits over 24 fraction bits
`define FRAC_BITS 24
`define PROD_W 48
`define ACC_W 72

// Accumulator and counter slots, five per channel
`define KIND_COUNT 10
`define CHAN_STRIDE 5
`define KIND_ACT_IMP 0
`define KIND_ACT_EXP 1
`define KIND_REA_IMP 2
`define KIND_REA_EXP 3
`define KIND_APPARENT 4

// Reset values
`define UNIT_INT_RESET 24'h000000
`define UNIT_FRAC_RESET 24'h000000
`define SLOT_RESET 16'h0000
`define COUNT_RESET 24'h000000
`define VALUE_RESET 24'h000000

`endif

// ==== minmax_tracker.sv ====
// Walks the tracking slots after each interval and keeps min and max
`default_nettype none
`include "energy_track_regs.svh"

module minmax_tracker
   import energy_track_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic start,
   input wire logic clear,
   input wire slot_table_t slot_table,
   input wire word_t result_data,
   output logic result_rd,
   output slot_ptr_t result_addr,
   output value_table_t minimum_value,
   output value_table_t maximum_value,
   output logic update
);

   track_state_e state_reg, state_next;
   slot_idx_t slot_reg, slot_next;
   logic [`SLOT_COUNT-1:0] seen_reg, seen_next;
   value_table_t min_reg, min_next, max_reg, max_next;
   logic rd_next, update_next;
   slot_ptr_t addr_next;

   always_comb begin
      state_next = state_reg;
      slot_next = slot_reg;
      seen_next = seen_reg;
      min_next = min_reg;
      max_next = max_reg;
      rd_next = 1'b0;
      addr_next = result_addr;
      update_next = 1'b0;
      if (clear) begin
         // Results live only in volatile storage
         state_next = TRACK_IDLE;
         seen_next = '0;
         min_next = '0;
         max_next = '0;
      end else begin
         case (state_reg)
            TRACK_IDLE: begin
               if (start) begin
                  slot_next = '0;
                  state_next = TRACK_ISSUE;
               end
            end
            TRACK_ISSUE: begin
               if (slot_reg == slot_idx_t'(`SLOT_COUNT)) begin
                  state_next = TRACK_IDLE;
               end else if (slot_table[slot_reg] == `SLOT_RESET) begin
                  slot_next = slot_idx_t'(slot_reg + 3'h1);
               end else begin
                  // Pointer is a word address, passed through as is
                  rd_next = 1'b1;
                  addr_next = slot_table[slot_reg];
                  state_next = TRACK_WAIT;
               end
            end
            TRACK_WAIT: begin
               state_next = TRACK_CAPTURE;
            end
            TRACK_CAPTURE: begin
               // First sample after a clear seeds both ends
               if (!seen_reg[slot_reg] ||
                   $signed(result_data) < $signed(min_reg[slot_reg])) begin
                  min_next[slot_reg] = result_data;
                  update_next = 1'b1;
               end
               if (!seen_reg[slot_reg] ||
                   $signed(result_data) > $signed(max_reg[slot_reg])) begin
                  max_next[slot_reg] = result_data;
                  update_next = 1'b1;
               end
               seen_next[slot_reg] = 1'b1;
               slot_next = slot_idx_t'(slot_reg + 3'h1);
               state_next = TRACK_ISSUE;
            end
            default: state_next = TRACK_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg <= TRACK_IDLE;
         slot_reg <= '0;
         seen_reg <= '0;
         min_reg <= '0;
         max_reg <= '0;
         result_rd <= 1'b0;
         result_addr <= `SLOT_RESET;
         update <= 1'b0;
      end else if (ce) begin
         state_reg <= state_next;
         slot_reg <= slot_next;
         seen_reg <= seen_next;
         min_reg <= min_next;
         max_reg <= max_next;
         result_rd <= rd_next;
         result_addr <= addr_next;
         update <= update_next;
      end
   end

   assign minimum_value = min_reg;
   assign maximum_value = max_reg;

   ////////////////////////////////////////////////////////////////////////
   zero_slot_skip_a: assert property (@(posedge clk) disable iff (reset)
      result_rd |-> result_addr != `SLOT_RESET)
      else $error("read issued for a disabled slot");

   min_below_max_a: assert property (@(posedge clk) disable iff (reset)
      seen_reg[0] |-> $signed(min_reg[0]) <= $signed(max_reg[0]))
      else $error("slot 0 minimum above maximum");

   tracker_clear_a: assert property (@(posedge clk) disable iff (reset)
      ce && clear |=> seen_reg == '0 && min_reg == '0 && max_reg == '0)
      else $error("tracker not cleared");

   capture_timing_a: assert property (@(posedge clk) disable iff (reset)
      ce && result_rd && !clear |=> state_reg == TRACK_CAPTURE)
      else $error("capture did not follow read");
endmodule : minmax_tracker

`default_nettype wire

// ==== result_source.sv ====
// Behavioural source of the low-rate results read by the min/max tracker
`default_nettype none

module result_source
   import energy_track_pkg::*;
(
   input wire logic clk,
   input wire word_t base,
   input wire logic result_rd,
   input wire slot_ptr_t result_addr,
   output word_t result_data
);
   // Valid only the cycle after a read; flips otherwise so stale data shows
   always @(posedge clk) begin
      if (result_rd === 1'b1) begin
         result_data <= base + word_t'(result_addr);
      end else begin
         result_data <= ~result_data;
      end
   end
endmodule : result_source

`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the energy counters and min/max tracker
`default_nettype none

module tb
   import energy_track_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, reset = 1, ce = 1, interval_done = 0, clear_request = 0;
   logic unit_int_wr = 0, unit_frac_wr = 0, slot_wr = 0, nv_save_request = 0;
   logic reset_flag_clear = 0, minmax_flag_clear = 0;
   word_t samples_per_interval = 0, active_power_a = 0, active_power_b = 0;
   word_t reactive_power_a = 0, reactive_power_b = 0, apparent_power_a = 0;
   word_t apparent_power_b = 0, unit_wdata = 0, base = 0, result_data;
   slot_idx_t slot_index = 0;
   slot_ptr_t slot_wdata = 0, result_addr;
   logic [47:0] nv_unit_default = 48'h000001000000, nv_unit_data;
   slot_table_t nv_slot_default = '0, track_slot_pointer;
   logic result_rd, reset_flag, minmax_updated, nv_write;
   word_t active_import_count_a, active_export_count_a, reactive_import_count_a;
   word_t reactive_export_count_a, apparent_energy_count_a;
   word_t active_import_count_b, active_export_count_b, reactive_import_count_b;
   word_t reactive_export_count_b, apparent_energy_count_b;
   word_t energy_unit_integer_word, energy_unit_fraction_word, interval_count;
   value_table_t minimum_value, maximum_value;
   int mismatches = 0, checks_done = 0, seed = 83, cycles = 0, n_int = 0;
   int n, pa, pb, qa, qb, sa, sb, v0, v1, w0, w1;
   logic [47:0] exp_q[$];
   logic [47:0] obs_q[$];
   event look;

   energy_bucket_minmax_tracker dut_u (.clk, .reset, .ce, .interval_done,
      .samples_per_interval, .active_power_a, .active_power_b,
      .reactive_power_a, .reactive_power_b, .apparent_power_a,
      .apparent_power_b, .clear_request, .unit_int_wr, .unit_frac_wr,
      .unit_wdata, .slot_wr, .slot_index, .slot_wdata, .nv_unit_default,
      .nv_slot_default, .nv_save_request, .reset_flag_clear,
      .minmax_flag_clear, .result_data, .result_rd, .result_addr,
      .active_import_count_a, .active_export_count_a,
      .reactive_import_count_a, .reactive_export_count_a,
      .apparent_energy_count_a, .active_import_count_b,
      .active_export_count_b, .reactive_import_count_b,
      .reactive_export_count_b, .apparent_energy_count_b,
      .energy_unit_integer_word, .energy_unit_fraction_word,
      .track_slot_pointer, .interval_count, .reset_flag, .minmax_updated,
      .minimum_value, .maximum_value, .nv_write, .nv_unit_data,
      .nv_slot_data());
   result_source src_u (.clk, .base, .result_rd, .result_addr, .result_data);

   always #50 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run

   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Notes the expectation; the watcher below does the comparing
   task automatic expect_val(input logic [47:0] seen, input logic [47:0] e);
      exp_q.push_back(e);
      obs_q.push_back(seen);
      -> look;
   endtask : expect_val

   always @(look) begin
      while (obs_q.size() > 0) begin
         check(obs_q.pop_front(), exp_q.pop_front());
      end
   end

   always @(posedge clk) begin
      if (nv_write === 1'b1) begin
         check(nv_unit_data, exp_q.pop_front());
      end
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         complete_run();
      end
   end

   task automatic tick(input int k);
      repeat (k) @(negedge clk);
   endtask : tick

   task automatic pulse(ref logic s);
      s = 1;
      tick(1);
      s = 0;
   endtask : pulse

   task automatic do_reset();
      reset = 1;
      tick(12);
      reset = 0;
      n_int = 0;
      tick(3);
   endtask : do_reset

   task automatic set_unit(input word_t hi, input word_t lo);
      unit_wdata = hi;
      pulse(unit_int_wr);
      unit_wdata = lo;
      pulse(unit_frac_wr);
   endtask : set_unit

   task automatic set_slot(input int i, input slot_ptr_t p);
      slot_index = slot_idx_t'(i);
      slot_wdata = p;
      pulse(slot_wr);
      tick(1);
   endtask : set_slot

   // Channel a power sits on the inputs only while the interval strobe is high; channel b power stays
   task automatic interval(input int ap, bp, aq, bq, as, bs, k);
      {active_power_a, active_power_b} = {word_t'(ap), word_t'(bp)};
      {reactive_power_a, reactive_power_b} = {word_t'(aq), word_t'(bq)};
      {apparent_power_a, apparent_power_b} = {word_t'(as), word_t'(bs)};
      samples_per_interval = word_t'(k);
      pulse(interval_done);
      {active_power_a, reactive_power_a, apparent_power_a} = '1;
      n_int++;
      tick(30);
   endtask : interval

   function automatic word_t part(input int p, input int k, input bit neg);
      return word_t'((neg ? p < 0 : p > 0) ? (neg ? -p : p) * k : 0);
   endfunction : part

   function automatic int sx(input int v);
      return int'($signed(word_t'(v)));
   endfunction : sx

   ////////////////////////////////////////////////////////////////////////
   initial begin
      do_reset();
      expect_val(reset_flag, 1);
      expect_val(energy_unit_integer_word, 1);
      expect_val(interval_count, 0);
      pulse(reset_flag_clear);
      tick(1);
      expect_val(reset_flag, 0);
      $display("test reset done");
      // Random powers, unit of exactly one
      for (int t = 0; t < 3; t++) begin
         pulse(clear_request);
         n = 1 + ($random(seed) & 3);
         pa = $random(seed) % 5;
         pb = $random(seed) % 5;
         qa = $random(seed) % 5;
         qb = $random(seed) % 5;
         sa = $random(seed) & 7;
         sb = $random(seed) & 7;
         interval(pa, pb, qa, qb, sa, sb, n);
         expect_val(active_import_count_a, part(pa, n, 0));
         expect_val(active_export_count_a, part(pa, n, 1));
         expect_val(reactive_import_count_a, part(qa, n, 0));
         expect_val(reactive_export_count_a, part(qa, n, 1));
         expect_val(apparent_energy_count_a, word_t'(sa * n));
         expect_val(active_import_count_b, part(pb, n, 0));
         expect_val(active_export_count_b, part(pb, n, 1));
         expect_val(reactive_import_count_b, part(qb, n, 0));
         expect_val(reactive_export_count_b, part(qb, n, 1));
         expect_val(apparent_energy_count_b, word_t'(sb * n));
      end
      $display("test energy done");
      // Unit of one and a half keeps the remainder between steps
      set_unit(24'h000001, 24'h800000);
      expect_val(energy_unit_fraction_word, 24'h800000);
      pulse(clear_request);
      for (int t = 0; t < 3; t++) begin
         interval(1, 0, 0, 0, 0, 0, 1);
         expect_val(active_import_count_a, t);
      end
      expect_val(interval_count, n_int);
      $display("test remainder done");
      // Min/max with one disabled slot between two live ones
      pulse(clear_request);
      set_slot(0, 16'h0010);
      set_slot(2, 16'h0020);
      v0 = $random(seed);
      v1 = $random(seed);
      base = word_t'(v0);
      // Negative power here exercises the export path under a live unit
      interval(-2, 0, 0, 0, 0, 0, 1);
      base = word_t'(v1);
      interval(0, 0, 0, 0, 0, 0, 1);
      w0 = sx(v0 + 16);
      w1 = sx(v1 + 16);
      expect_val(minimum_value[0], word_t'(w0 < w1 ? w0 : w1));
      expect_val(maximum_value[0], word_t'(w0 < w1 ? w1 : w0));
      w0 = sx(v0 + 32);
      w1 = sx(v1 + 32);
      expect_val(maximum_value[2], word_t'(w0 < w1 ? w1 : w0));
      expect_val(maximum_value[1], 0);
      expect_val(track_slot_pointer[2], 16'h0020);
      expect_val(minmax_updated, 1);
      pulse(minmax_flag_clear);
      tick(1);
      expect_val(minmax_updated, 0);
      pulse(clear_request);
      tick(1);
      expect_val(minimum_value[0], 0);
      expect_val(active_import_count_a, 0);
      expect_val(interval_count, n_int);
      $display("test minmax done");
      // Clock enable low must freeze everything, interval strobe included
      ce = 0;
      pulse(interval_done);
      ce = 1;
      expect_val(interval_count, n_int);
      exp_q.push_back(48'h000001800000);
      pulse(nv_save_request);
      tick(3);
      $display("test save done");
      do_reset();
      expect_val(reset_flag, 1);
      expect_val(interval_count, 0);
      expect_val(energy_unit_fraction_word, 0);
      $display("test second reset done");
      complete_run();
   end
endmodule : tb

`default_nettype wire
